// >>> tpx_prescaler.sv
module tpx_prescaler (
	input  wire logic                  CLOCK_I,
	input  wire logic                  RST_N_I,
	input  wire tpx_pkg::tpx_ahb_req_s AHB_I,
	output      tpx_pkg::tpx_ahb_rsp_s AHB_O,
	input  wire logic [1:0]            EXT_COUNT_PIN_I,      // ext_count_pin for timer 0, 1
	output      logic [1:0]            COUNTER_CLOCK_PULSE_O // one-cycle count enables
);
	import tpx_pkg::*;

	// prescaler and control state
	logic [PRESC_W-1:0] presc;          // shared free-running divider
	logic               sync_hold_mode; // keeps prescaler_reset_bit as written
	logic               prescaler_reset_bit;
	tpx_cs_e            sel [2];        // count_clock_select per timer
	logic               wr_pend;        // data phase of a write pending
	logic               rd_pend;        // data phase of a read pending
	logic [7:0]         addr_q;         // address captured in address phase
	logic [31:0]        rdata;          // registered read data
	logic [1:0]         pin_s1, pin_s2, pin_s3; // three-stage pin synchroniser
	logic [1:0]         pin_lvl;        // agreed level after stages two and three
	logic [1:0]         pulse;          // registered count pulses

	// tap decode: a tap fires when all lower bits are ones, i.e. at rollover
	function automatic logic tap_hit(input logic [PRESC_W-1:0] v, input logic [PRESC_W-1:0] m);
		return (v & m) == m;
	endfunction

	// count source mux, shared by both timers
	function automatic logic src_pulse(input tpx_cs_e cs, input logic [PRESC_W-1:0] v,
		input logic rise, input logic fall, input logic hold);
		unique case (cs)
			TPX_CS_STOP:    return 1'b0;
			TPX_CS_DIV1:    return 1'b1;
			TPX_CS_DIV8:    return !hold && tap_hit(v, TAP8_MASK);
			TPX_CS_DIV64:   return !hold && tap_hit(v, TAP64_MASK);
			TPX_CS_DIV256:  return !hold && tap_hit(v, TAP256_MASK);
			TPX_CS_DIV1024: return !hold && tap_hit(v, TAP1024_MASK);
			TPX_CS_FALL:    return fall;
			TPX_CS_RISE:    return rise;
		endcase
	endfunction

	// bus decode
	wire        addr_ph   = AHB_I.hsel && AHB_I.hready &&
		(AHB_I.htrans == HTRANS_NONSEQ || AHB_I.htrans == HTRANS_SEQ);
	wire        wr_ctrl   = wr_pend && addr_q == ADDR_GTCTRL;
	wire        wr_sel    = wr_pend && addr_q == ADDR_SEL;
	wire        wd_hold   = AHB_I.hwdata[BIT_SYNC_HOLD];
	wire        wd_psr    = AHB_I.hwdata[BIT_PSC_RST];
	// the prescaler reset only holds the divider; it never stops select 1 or the pin path
	wire        presc_hold = prescaler_reset_bit;
	// an edge counts once stages two and three agree on a new level
	wire [1:0]  agree     = ~(pin_s2 ^ pin_s3);
	wire [1:0]  next_lvl  = (agree & pin_s3) | (~agree & pin_lvl);
	wire [1:0]  rise      = next_lvl & ~pin_lvl;
	wire [1:0]  fall      = ~next_lvl & pin_lvl;
	// one-cycle count pulse per timer
	wire [1:0]  next_pulse = {src_pulse(sel[1], presc, rise[1], fall[1], presc_hold),
		src_pulse(sel[0], presc, rise[0], fall[0], presc_hold)};

	// read mux decodes the live address phase, so the flopped word stands for the whole
	// data phase; decoding the captured address would land the data one cycle too late
	wire [31:0] next_rdata =
		(AHB_I.haddr == ADDR_GTCTRL) ? {24'h000000, sync_hold_mode, 6'h00, prescaler_reset_bit} :
		(AHB_I.haddr == ADDR_SEL)    ? {24'h000000, 1'b0, sel[1], 1'b0, sel[0]} :
		(AHB_I.haddr == ADDR_STATUS) ? {14'h0000, pin_lvl, 6'h00, presc} :
		32'h00000000;

	assign AHB_O.hrdata    = rdata;
	assign AHB_O.hreadyout = 1'b1;   // zero wait states
	assign AHB_O.hresp     = 1'b0;   // always okay
	assign COUNTER_CLOCK_PULSE_O = pulse;

	// shared divider: free running whatever the selects say
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I || presc_hold) begin
			presc <= PRESC_RST;
		end else begin
			presc <= presc + 10'h001;
		end
	end

	// control register: hold-mode bit and self-clearing prescaler reset
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			sync_hold_mode      <= 1'b0;
			prescaler_reset_bit <= 1'b0;
		end else if (wr_ctrl) begin
			sync_hold_mode      <= wd_hold;
			// the written value stands in either mode; out of hold mode the next clock without a control write clears it
			prescaler_reset_bit <= wd_hold ? wd_psr : wd_psr;
		end else if (!sync_hold_mode) begin
			prescaler_reset_bit <= 1'b0;
		end
	end

	// clock selects: changing them never touches the divider
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			sel[0] <= TPX_CS_STOP;
			sel[1] <= TPX_CS_STOP;
		end else if (wr_sel) begin
			sel[0] <= tpx_cs_e'(AHB_I.hwdata[2:0]);
			sel[1] <= tpx_cs_e'(AHB_I.hwdata[SEL1_LSB +: 3]);
		end
	end

	// ahb-lite address/data phase tracking
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			addr_q  <= 8'h00;
			rdata   <= 32'h00000000;
		end else begin
			wr_pend <= addr_ph && AHB_I.hwrite;
			rd_pend <= addr_ph && !AHB_I.hwrite;
			if (addr_ph) begin
				addr_q <= AHB_I.haddr;
				rdata  <= next_rdata;   // captured at the address phase edge
			end
		end
	end

	// pin sampling: stage one stands for the transparent latch, read only by stage two
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			pin_s1   <= 2'b00;
			pin_s2   <= 2'b00;
			pin_s3   <= 2'b00;
			pin_lvl  <= 2'b00;
		end else begin
			pin_s1   <= EXT_COUNT_PIN_I;
			pin_s2   <= pin_s1;
			pin_s3   <= pin_s2;
			pin_lvl  <= next_lvl;
		end
	end

	// count pulses leave a flip-flop; pin path latency lands near three clocks
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			pulse <= 2'b00;
		end else begin
			pulse <= next_pulse;
		end
	end

	// a stopped timer never sees a count
	property p_stop;
		@(posedge CLOCK_I) disable iff (!RST_N_I)
		(sel[0] == TPX_CS_STOP) |=> !pulse[0];
	endproperty
	a_stop: assert property (p_stop) else $error("count with select 0");

	// undivided select counts every clock
	property p_div1;
		@(posedge CLOCK_I) disable iff (!RST_N_I)
		(sel[0] == TPX_CS_DIV1) |=> pulse[0];
	endproperty
	a_div1: assert property (p_div1) else $error("select 1 missed a clock");

	// divide-by-8 tap fires when low three bits roll over
	property p_tap8;
		@(posedge CLOCK_I) disable iff (!RST_N_I)
		(sel[1] == TPX_CS_DIV8 && !presc_hold && presc[2:0] == 3'h7) |=> pulse[1];
	endproperty
	a_tap8: assert property (p_tap8) else $error("div8 tap missed");

	// no two divide-by-8 pulses closer than eight clocks
	property p_tap8_gap;
		@(posedge CLOCK_I) disable iff (!RST_N_I)
		(pulse[1] && $past(sel[1]) == TPX_CS_DIV8 && sel[1] == TPX_CS_DIV8) |=>
			!pulse[1] [*7];
	endproperty
	a_tap8_gap: assert property (p_tap8_gap) else $error("div8 pulses too close");

	// divider advances by one unless held
	property p_free;
		@(posedge CLOCK_I) disable iff (!RST_N_I)
		!presc_hold |=> presc == $past(presc) + 10'h001;
	endproperty
	a_free: assert property (p_free) else $error("prescaler did not advance");

	// held prescaler reads zero next clock
	property p_hold;
		@(posedge CLOCK_I) disable iff (!RST_N_I)
		presc_hold |=> presc == PRESC_RST;
	endproperty
	a_hold: assert property (p_hold) else $error("prescaler not held");

	// reset bit clears itself out of hold mode
	property p_selfclr;
		@(posedge CLOCK_I) disable iff (!RST_N_I)
		(prescaler_reset_bit && !sync_hold_mode && !wr_ctrl) |=> !prescaler_reset_bit;
	endproperty
	a_selfclr: assert property (p_selfclr) else $error("reset bit stuck");

	// in hold mode the reset bit stays until written
	property p_keep;
		@(posedge CLOCK_I) disable iff (!RST_N_I)
		(prescaler_reset_bit && sync_hold_mode && !wr_ctrl) |=> prescaler_reset_bit;
	endproperty
	a_keep: assert property (p_keep) else $error("reset bit lost in hold");

	// stable pin rise reaches the pulse three clocks after its first sample
	sequence s_pin_rise;
		!pin_s1[0] ##1 pin_s1[0] [*3];
	endsequence
	property p_rise;
		@(posedge CLOCK_I) disable iff (!RST_N_I)
		(s_pin_rise and (sel[0] == TPX_CS_RISE) [*4] and !pin_lvl[0] [*3]) |=> pulse[0];
	endproperty
	a_rise: assert property (p_rise) else $error("rising pin edge not counted");

	// falling select never counts on a rising level change
	property p_fall_only;
		@(posedge CLOCK_I) disable iff (!RST_N_I)
		(sel[0] == TPX_CS_FALL && rise[0]) |=> !pulse[0];
	endproperty
	a_fall_only: assert property (p_fall_only) else $error("falling select counted a rise");

	// stable pin fall reaches timer 1 three clocks after its first sample
	sequence s_pin_fall;
		pin_s1[1] ##1 !pin_s1[1] [*3];
	endsequence
	property p_fall;
		@(posedge CLOCK_I) disable iff (!RST_N_I)
		(s_pin_fall and (sel[1] == TPX_CS_FALL) [*4] and pin_lvl[1] [*3]) |=> pulse[1];
	endproperty
	a_fall: assert property (p_fall) else $error("falling pin edge not counted");

	// rising select never counts on a falling level change
	property p_rise_only;
		@(posedge CLOCK_I) disable iff (!RST_N_I)
		(sel[0] == TPX_CS_RISE && fall[0]) |=> !pulse[0];
	endproperty
	a_rise_only: assert property (p_rise_only) else $error("rising select counted a fall");

	// divide-by-64 tap fires at its rollover
	property p_tap64;
		@(posedge CLOCK_I) disable iff (!RST_N_I)
		(sel[0] == TPX_CS_DIV64 && !presc_hold && tap_hit(presc, TAP64_MASK)) |=> pulse[0];
	endproperty
	a_tap64: assert property (p_tap64) else $error("div64 tap missed");

	// divide-by-256 tap fires at its rollover
	property p_tap256;
		@(posedge CLOCK_I) disable iff (!RST_N_I)
		(sel[0] == TPX_CS_DIV256 && !presc_hold && tap_hit(presc, TAP256_MASK)) |=> pulse[0];
	endproperty
	a_tap256: assert property (p_tap256) else $error("div256 tap missed");

	// divide-by-1024 tap fires at its rollover
	property p_tap1024;
		@(posedge CLOCK_I) disable iff (!RST_N_I)
		(sel[1] == TPX_CS_DIV1024 && !presc_hold && tap_hit(presc, TAP1024_MASK)) |=> pulse[1];
	endproperty
	a_tap1024: assert property (p_tap1024) else $error("div1024 tap missed");

	// a divide-by-8 timer stays quiet away from the rollover
	property p_tap8_quiet;
		@(posedge CLOCK_I) disable iff (!RST_N_I)
		(sel[0] == TPX_CS_DIV8 && !tap_hit(presc, TAP8_MASK)) |=> !pulse[0];
	endproperty
	a_tap8_quiet: assert property (p_tap8_quiet) else $error("div8 counted off rollover");

	// a held prescaler gives no prescaled counts
	property p_tap_held;
		@(posedge CLOCK_I) disable iff (!RST_N_I)
		(presc_hold && sel[0] inside {TPX_CS_DIV8, TPX_CS_DIV64, TPX_CS_DIV256,
			TPX_CS_DIV1024}) |=> !pulse[0];
	endproperty
	a_tap_held: assert property (p_tap_held) else $error("tap counted while held");

	// a control write sets the hold-mode bit as written
	property p_ctrl_write;
		@(posedge CLOCK_I) disable iff (!RST_N_I)
		wr_ctrl |=> sync_hold_mode == $past(wd_hold);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("hold mode not written");

	// leaving hold mode clears the reset bit one clock later
	property p_release;
		@(posedge CLOCK_I) disable iff (!RST_N_I)
		(wr_ctrl && !wd_hold) |=> ##1 (!prescaler_reset_bit || $past(wr_ctrl));
	endproperty
	a_release: assert property (p_release) else $error("reset bit kept after release");

	// a control read returns both bits through the data phase
	property p_rd_ctrl;
		@(posedge CLOCK_I) disable iff (!RST_N_I)
		(addr_ph && !AHB_I.hwrite && AHB_I.haddr == ADDR_GTCTRL) |=>
			(AHB_O.hrdata[BIT_PSC_RST] == $past(prescaler_reset_bit) &&
			AHB_O.hrdata[BIT_SYNC_HOLD] == $past(sync_hold_mode));
	endproperty
	a_rd_ctrl: assert property (p_rd_ctrl) else $error("control read mismatch");
endmodule

// >>> tpx_pkg.sv
// Overview of operation
// - one shared prescaler, per-timer clock selects
// - select 1 counts every system clock
// - taps at divide by 8, 64, 256, 1024
// - prescaler free-running, unaffected by selects
// - first prescaled count within 1..N+1 clocks
// - pin sampled each clock, then edge detected
// - latch-equivalent front then rising-edge flip-flops
// - select 7 rising, select 6 falling pin edges
// - pin edge to count 3..4 clocks
// - pin pulses bypass the prescaler divider
// - sync hold mode keeps prescaler reset bit
// - clearing sync hold mode clears reset bit
// - reset bit holds prescaler, self-clears otherwise
// - select 0 gives no count clock
package tpx_pkg;
	localparam int unsigned PRESC_W        = 10;      // prescaler counter width
	localparam logic [9:0]  TAP8_MASK      = 10'h007; // low bits all ones before /8 rollover
	localparam logic [9:0]  TAP64_MASK     = 10'h03f;
	localparam logic [9:0]  TAP256_MASK    = 10'h0ff;
	localparam logic [9:0]  TAP1024_MASK   = 10'h3ff;
	localparam logic [9:0]  PRESC_RST      = 10'h000;
	// register map: byte addresses
	localparam logic [7:0]  ADDR_GTCTRL    = 8'h00;   // general_timer_control
	localparam logic [7:0]  ADDR_SEL       = 8'h04;   // count_clock_select for both timers
	localparam logic [7:0]  ADDR_STATUS    = 8'h08;   // prescaler value, synced pin level
	localparam int unsigned BIT_SYNC_HOLD  = 7;       // sync_hold_mode
	localparam int unsigned BIT_PSC_RST    = 0;       // prescaler_reset_bit
	localparam int unsigned SEL1_LSB       = 4;       // timer 1 select field position
	localparam int unsigned STAT_PIN0_BIT  = 16;
	localparam int unsigned STAT_PIN1_BIT  = 17;
	localparam logic [1:0]  HTRANS_NONSEQ  = 2'b10;
	localparam logic [1:0]  HTRANS_SEQ     = 2'b11;

	// count clock select encodings
	typedef enum logic [2:0] {
		TPX_CS_STOP  = 3'h0,
		TPX_CS_DIV1  = 3'h1,
		TPX_CS_DIV8  = 3'h2,
		TPX_CS_DIV64 = 3'h3,
		TPX_CS_DIV256 = 3'h4,
		TPX_CS_DIV1024 = 3'h5,
		TPX_CS_FALL  = 3'h6,
		TPX_CS_RISE  = 3'h7
	} tpx_cs_e;

	// ahb-lite request from the master
	typedef struct packed {
		logic        hsel;
		logic [7:0]  haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic        hready;
		logic [31:0] hwdata;
	} tpx_ahb_req_s;

	// ahb-lite answer from the slave
	typedef struct packed {
		logic [31:0] hrdata;
		logic        hreadyout;
		logic        hresp;
	} tpx_ahb_rsp_s;
endpackage

// >>> tpx_ext_src.sv
// behavioural external clock source on the count pins
module tpx_ext_src (
	input  wire logic       CLOCK_I,         // system clock, used only to pace edges
	output      logic [1:0] EXT_COUNT_PIN_O  // both pins toggle together
);
	timeunit 1ns;
	timeprecision 1ps;

	// pins rest low between bursts so selects can change on a quiet pin
	initial EXT_COUNT_PIN_O = 2'b00;

	// n full periods; half period in clocks kept above one clock
	task automatic burst(input int n, input int half);
		for (int i = 0; i < n; i++) begin
			repeat (half) @(posedge CLOCK_I);
			EXT_COUNT_PIN_O <= 2'b11;
			repeat (half) @(posedge CLOCK_I);
			EXT_COUNT_PIN_O <= 2'b00;
		end
	endtask
endmodule

// >>> test_timer_prescaler_ext_clock.sv
module test_timer_prescaler_ext_clock;
	timeunit 1ns;
	timeprecision 1ps;
	import tpx_pkg::*;

	logic         clock;      // 200 mhz system clock
	logic         rst_n;      // synchronous reset, active low
	logic         bus_sel;    // master request fields
	logic [7:0]   bus_addr;
	logic [1:0]   bus_trans;
	logic         bus_write;
	logic [2:0]   bus_size;
	logic [31:0]  bus_wdata;
	tpx_ahb_req_s ahb_req;
	tpx_ahb_rsp_s ahb_rsp;
	logic [1:0]   pin;        // count pins from the partner
	logic [1:0]   pulse;      // count enables seen
	logic [31:0]  cnt0;       // running pulse tallies per timer
	logic [31:0]  cnt1;
	logic [31:0]  rd;
	int           num_errors;
	int           num_checks;

	// the single slave's hreadyout closes the loop as bus hready
	assign ahb_req = '{hsel: bus_sel, haddr: bus_addr, htrans: bus_trans, hwrite: bus_write,
		hsize: bus_size, hready: ahb_rsp.hreadyout, hwdata: bus_wdata};

	tpx_prescaler i_tpx_prescaler (.CLOCK_I(clock), .RST_N_I(rst_n), .AHB_I(ahb_req),
		.AHB_O(ahb_rsp), .EXT_COUNT_PIN_I(pin), .COUNTER_CLOCK_PULSE_O(pulse));
	tpx_ext_src i_tpx_ext_src (.CLOCK_I(clock), .EXT_COUNT_PIN_O(pin));

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// tallies let windows be judged by difference, whatever the phase
	always_ff @(posedge clock) begin
		cnt0 <= rst_n ? cnt0 + 32'(pulse[0]) : 32'h0;
		cnt1 <= rst_n ? cnt1 + 32'(pulse[1]) : 32'h0;
	end

	task automatic results();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// sample just before each edge, so the value is the one that edge takes
	task automatic wait_rdy(output logic [31:0] d);
		int   n;
		logic ok;
		n = 0;
		do begin
			@(negedge clock);
			ok = ahb_rsp.hreadyout;
			d = ahb_rsp.hrdata;
			@(posedge clock);
			n++;
		end while (ok !== 1'b1 && n < 50);
		if (ok !== 1'b1) begin
			num_errors++;
			$display("[ERR] bus wait expired");
			results();
		end
	endtask

	// one single word transfer: address phase, then data phase
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clock);
		bus_sel <= 1'b1;
		bus_trans <= HTRANS_NONSEQ;
		bus_addr <= a;
		bus_write <= wr;
		bus_size <= 3'h2;
		wait_rdy(rd);
		bus_sel <= 1'b0;
		bus_trans <= 2'b00;
		bus_wdata <= wd;
		wait_rdy(rd);
	endtask

	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(what, exp, rd);
	endtask

	// pulses per timer over a window of cyc clocks
	task automatic win(input int cyc, input logic [31:0] e0, input logic [31:0] e1);
		logic [31:0] s0;
		logic [31:0] s1;
		s0 = cnt0;
		s1 = cnt1;
		repeat (cyc) @(posedge clock);
		chk("timer0 pulses", e0, cnt0 - s0);
		chk("timer1 pulses", e1, cnt1 - s1);
	endtask

	// registers after reset, unmapped access, stopped selects
	task automatic s_regs();
		rdchk("control reset", ADDR_GTCTRL, 32'h0);
		rdchk("select reset", ADDR_SEL, 32'h0);
		bus(1'b1, 8'h0c, 32'hffffffff);
		rdchk("unmapped", 8'h0c, 32'h0);
		win(64, 32'h0, 32'h0);
	endtask

	// undivided clock, then every tap with timer 1 on its own select
	task automatic s_taps();
		int div[4] = '{8, 64, 256, 1024};
		bus(1'b1, ADDR_SEL, 32'(TPX_CS_DIV1));
		repeat (3) @(posedge clock);
		win(100, 32'd100, 32'h0);
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, ADDR_SEL, (32'(TPX_CS_DIV1024) << SEL1_LSB) | 32'(3'h2 + 3'(i)));
			repeat (3) @(posedge clock);
			win(2048, 32'(2048 / div[i]), 32'd2);
		end
	endtask

	// self-clearing reset, hold mode, release and first count
	task automatic s_hold();
		bus(1'b1, ADDR_GTCTRL, 32'h01);
		rdchk("reset bit self clear", ADDR_GTCTRL, 32'h0);
		bus(1'b1, ADDR_SEL, (32'(TPX_CS_DIV1) << SEL1_LSB) | 32'(TPX_CS_DIV64));
		bus(1'b1, ADDR_GTCTRL, 32'h81);
		rdchk("reset bit kept", ADDR_GTCTRL, 32'h81);
		rdchk("status held", ADDR_STATUS, 32'h0);
		win(256, 32'h0, 32'd256);
		bus(1'b1, ADDR_GTCTRL, 32'h00);
		win(70, 32'd1, 32'd70);
		rdchk("reset bit released", ADDR_GTCTRL, 32'h0);
	endtask

	// pin edges: rising on timer 0, falling on timer 1, no division
	task automatic s_ext();
		logic [31:0] s0;
		logic [31:0] s1;
		bus(1'b1, ADDR_SEL, (32'(TPX_CS_FALL) << SEL1_LSB) | 32'(TPX_CS_RISE));
		repeat (4) @(posedge clock);
		s0 = cnt0;
		s1 = cnt1;
		i_tpx_ext_src.burst(5, 3);
		repeat (8) @(posedge clock);
		chk("rise pulses", 32'd5, cnt0 - s0);
		chk("fall pulses", 32'd5, cnt1 - s1);
	endtask

	// a hang anywhere ends in the closing report
	initial begin
		repeat (60000) @(posedge clock);
		num_errors++;
		$display("[ERR] run watchdog expired");
		results();
	end

	initial begin
		num_errors = 0;
		num_checks = 0;
		rst_n = 1'b0;
		{bus_sel, bus_addr, bus_trans, bus_write, bus_size, bus_wdata} = '0;
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		s_regs();
		s_taps();
		s_hold();
		s_ext();
		results();
	end
endmodule
